// ==== lineif_intr_pkg.sv ====
/*
 * Shared constants and carrier types for the per-channel alarm change
 * interrupt logic: register offsets, channel row ranges, reset values and
 * the packed structs that carry alarms, bus requests and channel state.
 * Assumes a byte-wide synchronous microprocessor port, 8-bit addresses.
 */
// Summary of operation
// - Enable bit 1 set: any change of receive signal loss raises interrupt.
// - Enable bit 1 is read/write; 0 disables, 1 enables signal loss interrupt.
// - Enable bit 0 set: drive monitor going to 1 or 0 raises interrupt.
// - Enable bit 0 is read/write; 0 disables, 1 enables drive monitor interrupt.
// - Flag bit 3 latches FIFO-limit change since last read; read clears it.
// - Alarm status bit 3 shows present FIFO-limit alarm state.
// - Flag bit 2 latches lock loss change since last read; read clears it.
// - Alarm status bit 2 shows present receive lock loss state.
// - Flags at address row-nibble then 2, rows 0-5 and 8-D; bits 7-4 reserved.
// - Enable bit 3 set: FIFO-limit alarm declare or clear raises interrupt.
// - Enable bit 2 set: lock loss declare or clear raises interrupt.
// - Flag bit 1 latches signal loss change since last read; read clears it.
// - Flag bit 0 latches drive monitor change since last read; read clears it.
package lineif_intr_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [3:0] OFS_ENABLES    = 4'h1;  // Low nibble, enable register
    localparam logic [3:0] OFS_FLAGS      = 4'h2;  // Low nibble, change flags
    localparam logic [3:0] OFS_ALARM      = 4'h3;  // Low nibble, present alarms
    localparam logic [3:0] ROW_LOW_LAST   = 4'h5;  // Rows 0..5 hold channels 0..5
    localparam logic [3:0] ROW_HIGH_FIRST = 4'h8;  // Rows 8..D hold channels 6..11
    localparam logic [3:0] ROW_HIGH_LAST  = 4'hD;
    localparam logic [3:0] ROW_GAP        = 4'h2;  // Upper bank row minus channel
    localparam int         NUM_CH_DEF     = 12;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [3:0] ENABLES_RST  = 4'h0;
    localparam logic [3:0] FLAGS_RST    = 4'h0;
    localparam logic [3:0] RESERVED_RD  = 4'h0;   // Bits 7..4 read value
    localparam logic [7:0] RDATA_RST    = 8'h00;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    // Bit 3 FIFO limit, bit 2 lock loss, bit 1 signal loss, bit 0 drive monitor
    typedef struct packed {
        logic fifo_limit_alarm;
        logic receive_lock_loss;
        logic receive_signal_loss;
        logic transmit_drive_monitor;
    } alarm_s;

    typedef struct packed {
        logic       rd;     // One-cycle read strobe
        logic       wr;     // One-cycle write strobe
        logic [7:0] addr;
        logic [7:0] wdata;
    } bus_req_s;

    typedef struct packed {
        logic   primed;     // Previous alarm sample is valid
        alarm_s prev;       // Alarm sample of the last enabled cycle
        alarm_s flags;      // Latched changes, cleared on read
        alarm_s enables;    // Per-source enables
    } chan_state_s;

endpackage

// ==== chan_addr_decode.sv ====
/*
 * Address decoder for the per-channel register rows: maps an 8-bit
 * address to a channel index, a low-nibble register offset and a hit flag.
 * Assumes purely combinational use inside the interrupt block.
 */
`timescale 1ns/1ps
module chan_addr_decode
    import lineif_intr_pkg::*;
#(
    parameter int NUM_CH = NUM_CH_DEF
) (
    input  wire logic [7:0] addr,
    output logic            hit,
    output logic [3:0]      ch_idx,
    output logic [3:0]      reg_ofs
);

    // ------------------------------------------------------------------
    // Row to channel mapping
    // ------------------------------------------------------------------
    logic [3:0] row;

    assign row     = addr[7:4];
    assign reg_ofs = addr[3:0];

    // Lower bank rows map straight, upper bank skips the shared rows
    always_comb begin
        hit    = 1'b0;
        ch_idx = 4'h0;
        if (row <= ROW_LOW_LAST) begin
            ch_idx = row;
            hit    = 1'b1;
        end else if (row >= ROW_HIGH_FIRST && row <= ROW_HIGH_LAST) begin
            ch_idx = 4'(row - ROW_GAP);
            hit    = 1'b1;
        end
        if (32'(ch_idx) >= NUM_CH) begin
            hit = 1'b0;
        end
    end

endmodule // chan_addr_decode

// ==== chan_alarm_intr.sv ====
/*
 * Per-channel alarm change interrupt logic. Each channel samples four alarm
 * conditions, latches every change in clear-on-read flags, gates the flags
 * with read/write enables and drives one registered interrupt request.
 * Assumes alarm inputs synchronous to clk and one-cycle port strobes.
 */
`timescale 1ns/1ps
module chan_alarm_intr
    import lineif_intr_pkg::*;
#(
    parameter int NUM_CH = NUM_CH_DEF
) (
    input  wire logic                clk,
    input  wire logic                rstn,
    input  wire logic                ce,
    input  wire bus_req_s            bus,
    input  wire alarm_s [NUM_CH-1:0] alarm,
    output logic [7:0]               rdata_r,
    output logic [NUM_CH-1:0]        chan_irq_r
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        chan_state_s [NUM_CH-1:0] ch;
        logic [NUM_CH-1:0]        irq;
        logic [7:0]               rdata;
    } top_state_s;

    top_state_s st_r;
    top_state_s st_nxt;

    logic              hit;
    logic [3:0]        ch_idx;
    logic [3:0]        reg_ofs;
    logic [NUM_CH-1:0] sel;
    logic [NUM_CH-1:0] rd_clr;
    logic [NUM_CH-1:0] wr_en;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    chan_addr_decode #(
        .NUM_CH  (NUM_CH)
    ) chan_addr_decode_inst (
        .addr    (bus.addr),
        .hit     (hit),
        .ch_idx  (ch_idx),
        .reg_ofs (reg_ofs)
    );

    // Per-channel selects for flag reads and enable writes
    for (genvar i = 0; i < NUM_CH; i++) begin : g_sel
        assign sel[i]    = hit && (ch_idx == 4'(i));
        assign rd_clr[i] = bus.rd && sel[i] && (reg_ofs == OFS_FLAGS);
        assign wr_en[i]  = bus.wr && sel[i] && (reg_ofs == OFS_ENABLES);
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Change detect, flag latch with set over clear, enable write, read mux
    always_comb begin
        logic [3:0] change;
        logic [7:0] rd_mux;
        change = 4'h0;
        rd_mux = RDATA_RST;
        st_nxt = st_r;
        if (ce) begin
            for (int i = 0; i < NUM_CH; i++) begin
                // First enabled cycle after reset only takes a sample
                change = st_r.ch[i].primed ? (alarm[i] ^ st_r.ch[i].prev) : 4'h0;
                st_nxt.ch[i].primed = 1'b1;
                st_nxt.ch[i].prev   = alarm[i];
                // A change in the clearing cycle survives the read
                st_nxt.ch[i].flags  = alarm_s'((rd_clr[i] ? FLAGS_RST
                                                          : st_r.ch[i].flags)
                                               | change);
                if (wr_en[i]) begin
                    st_nxt.ch[i].enables = alarm_s'(bus.wdata[3:0]);
                end
                // Request follows the flags and enables it will hold
                st_nxt.irq[i] = |(st_nxt.ch[i].flags
                                  & st_nxt.ch[i].enables);
                if (sel[i]) begin
                    case (reg_ofs)
                        OFS_ENABLES: rd_mux = {RESERVED_RD, st_r.ch[i].enables};
                        OFS_FLAGS:   rd_mux = {RESERVED_RD, st_r.ch[i].flags};
                        OFS_ALARM:   rd_mux = {RESERVED_RD, alarm[i]};
                        default:     rd_mux = RDATA_RST;
                    endcase
                end
            end
            if (bus.rd) begin
                st_nxt.rdata = rd_mux;
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Whole state held in one register; ce low freezes it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NUM_CH; i++) begin
                st_r.ch[i].primed  <= 1'b0;
                st_r.ch[i].prev    <= alarm_s'(FLAGS_RST);
                st_r.ch[i].flags   <= alarm_s'(FLAGS_RST);
                st_r.ch[i].enables <= alarm_s'(ENABLES_RST);
            end
            st_r.irq   <= '0;
            st_r.rdata <= RDATA_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata_r    = st_r.rdata;
    assign chan_irq_r = st_r.irq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    for (genvar i = 0; i < NUM_CH; i++) begin : g_chk
        // Each source change sets its flag on the next edge
        chk_los_change_flag: assert property (
            ce && st_r.ch[i].primed
               && (alarm[i].receive_signal_loss != st_r.ch[i].prev.receive_signal_loss)
            |=> st_r.ch[i].flags.receive_signal_loss)
            else $error("signal loss change not flagged");
        chk_lol_change_flag: assert property (
            ce && st_r.ch[i].primed
               && (alarm[i].receive_lock_loss != st_r.ch[i].prev.receive_lock_loss)
            |=> st_r.ch[i].flags.receive_lock_loss)
            else $error("lock loss change not flagged");
        chk_fl_change_flag: assert property (
            ce && st_r.ch[i].primed
               && (alarm[i].fifo_limit_alarm != st_r.ch[i].prev.fifo_limit_alarm)
            |=> st_r.ch[i].flags.fifo_limit_alarm)
            else $error("fifo limit change not flagged");
        chk_dmo_change_flag: assert property (
            ce && st_r.ch[i].primed
               && (alarm[i].transmit_drive_monitor
                   != st_r.ch[i].prev.transmit_drive_monitor)
            |=> st_r.ch[i].flags.transmit_drive_monitor)
            else $error("drive monitor change not flagged");
        // Read with steady alarms leaves all flags clear
        chk_read_clears: assert property (
            ce && rd_clr[i] && (alarm[i] == st_r.ch[i].prev)
            |=> st_r.ch[i].flags == alarm_s'(FLAGS_RST))
            else $error("flag read did not clear");
        // Flags hold without a read
        chk_flag_hold: assert property (
            ce && !rd_clr[i] |=> (st_r.ch[i].flags & $past(st_r.ch[i].flags))
                                 == $past(st_r.ch[i].flags))
            else $error("flag lost without a read");
        // Enable write lands exactly
        chk_enable_write: assert property (
            ce && wr_en[i] |=> st_r.ch[i].enables == alarm_s'($past(bus.wdata[3:0])))
            else $error("enable write not stored");
        // Request equals gated flags at all times
        chk_irq_gate: assert property (
            chan_irq_r[i] == |(st_r.ch[i].flags & st_r.ch[i].enables))
            else $error("request does not match gated flags");
        // Enabled drive monitor rise raises request on the next edge
        chk_dmo_irq: assert property (
            ce && st_r.ch[i].primed && st_r.ch[i].enables.transmit_drive_monitor
               && !wr_en[i] && alarm[i].transmit_drive_monitor
               && !st_r.ch[i].prev.transmit_drive_monitor
            |=> chan_irq_r[i])
            else $error("drive monitor change gave no request");
    end

    // Flag read returns zero in reserved bits
    chk_reserved_zero: assert property (
        ce && bus.rd && hit && (reg_ofs == OFS_FLAGS) |=> rdata_r[7:4] == RESERVED_RD)
        else $error("reserved flag bits not zero");
    // Alarm read mirrors present conditions of channel 0
    chk_alarm_mirror: assert property (
        ce && bus.rd && hit && (reg_ofs == OFS_ALARM) && (ch_idx == 4'h0)
        |=> rdata_r[3:0] == $past(alarm[0]))
        else $error("alarm read does not show present state");
    // Frozen clock enable keeps state
    chk_ce_freeze: assert property (
        !ce |=> $stable(st_r))
        else $error("state moved while clock enable low");

    cov_los_irq:    cover property (ce && st_r.ch[0].enables.receive_signal_loss
                                    ##1 chan_irq_r[0]);
    cov_read_clear: cover property (chan_irq_r[0] ##1 rd_clr[0] && ce ##1 !chan_irq_r[0]);
    cov_set_wins:   cover property (ce && rd_clr[0] && st_r.ch[0].primed
                                    && (alarm[0] != st_r.ch[0].prev));
    cov_upper_bank: cover property (ce && bus.rd && hit && (ch_idx == 4'hB));

endmodule // chan_alarm_intr

// ==== channel_alarm_change_interrupts_test.sv ====
/*
 * Self-checking testbench for the per-channel alarm change interrupt block:
 * enable read/write, clear-on-read change flags, present alarms, interrupt.
 * Assumes the package constants, one-cycle strobes and a registered read.
 */
`timescale 1ns/1ps
module channel_alarm_change_interrupts_test;
    import lineif_intr_pkg::*;

    localparam int NCH = 12;

    logic                 clk;
    logic                 rstn;
    logic                 ce;
    bus_req_s             bus;
    alarm_s [NCH-1:0]     alarm;
    logic [7:0]           rdata_r;
    logic [NCH-1:0]       chan_irq_r;
    int                   n_mismatch;
    int                   n_checks;
    logic [7:0]           rv;

    chan_alarm_intr #(.NUM_CH(NCH)) chan_alarm_intr_inst (
        .clk        (clk),
        .rstn       (rstn),
        .ce         (ce),
        .bus        (bus),
        .alarm      (alarm),
        .rdata_r    (rdata_r),
        .chan_irq_r (chan_irq_r)
    );

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    // Compare one value and count it
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            n_mismatch++;
        end
    endtask

    // One-cycle write strobe
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus.wr    <= 1'b1;
        bus.addr  <= a;
        bus.wdata <= d;
        @(posedge clk);
        bus.wr    <= 1'b0;
    endtask

    // One-cycle read strobe, data sampled after the taking edge
    task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        bus.rd   <= 1'b1;
        bus.addr <= a;
        @(posedge clk);
        bus.rd   <= 1'b0;
        #1;
        d = rdata_r;
    endtask

    // Drive one alarm bit and let the change be sampled
    task automatic set_alarm(input int c, input int b, input logic v);
        @(posedge clk);
        alarm[c][b] <= v;
        @(posedge clk);
        #1;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Reset values and enable register access
    task automatic enables_scenario();
        bus_rd(8'h01, rv); chk("enables rst", 8'h00, rv);
        bus_rd(8'h02, rv); chk("flags rst", 8'h00, rv);
        chk("irq rst", 8'h00, chan_irq_r[7:0]);
        bus_wr(8'h91, 8'hF5);
        bus_rd(8'h91, rv); chk("enables ch7", 8'h05, rv);
        bus_wr(8'h91, 8'h0A);
        bus_rd(8'h91, rv); chk("enables ch7", 8'h0A, rv);
        bus_wr(8'h91, 8'h00);
    endtask

    // Each source flagged on rise and fall, cleared on read, raises irq
    task automatic change_scenario();
        logic [7:0] m;
        for (int b = 0; b < 4; b++) begin
            m = 8'h01 << b;
            bus_wr(8'h01, m);
            set_alarm(0, b, 1'b1);
            chk("irq set", 8'h01, {7'h00, chan_irq_r[0]});
            bus_rd(8'h02, rv); chk("flags rise", m, rv);
            chk("irq cleared", 8'h00, {7'h00, chan_irq_r[0]});
            bus_rd(8'h02, rv); chk("flags clear", 8'h00, rv);
            bus_rd(8'h03, rv); chk("present", m, rv);
            set_alarm(0, b, 1'b0);
            chk("irq fall", 8'h01, {7'h00, chan_irq_r[0]});
            bus_rd(8'h02, rv); chk("flags fall", m, rv);
            bus_rd(8'h03, rv); chk("present off", 8'h00, rv);
        end
    endtask

    // Disabled source flags without irq; enabling later raises it
    task automatic disabled_scenario();
        bus_wr(8'h01, 8'h0D);
        set_alarm(0, 1, 1'b1);
        @(posedge clk);
        #1;
        chk("irq masked", 8'h00, {7'h00, chan_irq_r[0]});
        bus_wr(8'h01, 8'h02);
        @(posedge clk);
        #1;
        chk("irq late", 8'h01, {7'h00, chan_irq_r[0]});
        bus_rd(8'h02, rv); chk("flags masked", 8'h02, rv);
        chk("irq off", 8'h00, {7'h00, chan_irq_r[0]});
        set_alarm(0, 1, 1'b0);
        bus_rd(8'h02, rv);
    endtask

    // Channel rows, unmapped rows and frozen strobes
    task automatic map_scenario();
        set_alarm(11, 2, 1'b1);
        chk("irq ch11 masked", 8'h00, {7'h00, chan_irq_r[11]});
        bus_rd(8'hD2, rv); chk("flags ch11", 8'h04, rv);
        bus_rd(8'hC2, rv); chk("flags ch10", 8'h00, rv);
        bus_rd(8'h62, rv); chk("unmapped", 8'h00, rv);
        bus_wr(8'h61, 8'h0F);
        bus_rd(8'h61, rv); chk("unmapped wr", 8'h00, rv);
        bus_wr(8'h51, 8'h0F);
        @(posedge clk);
        ce <= 1'b0;
        bus_wr(8'h51, 8'h00);
        @(posedge clk);
        ce <= 1'b1;
        bus_rd(8'h51, rv); chk("enables ce", 8'h0F, rv);
    endtask

    // ------------------------------------------------------------------
    // Clock, reset, sequence and verdict
    // ------------------------------------------------------------------
    // Free-running 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Print counts and verdict, then stop
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        n_mismatch = 0;
        n_checks   = 0;
        rstn       = 1'b0;
        ce         = 1'b1;
        bus        = '0;
        alarm      = '0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        enables_scenario();
        change_scenario();
        disabled_scenario();
        map_scenario();
        complete_run();
    end

    // Watchdog against a hang
    initial begin
        #40000;
        n_mismatch++;
        complete_run();
    end

endmodule // channel_alarm_change_interrupts_test
